// ### src/adc_ctl_pkg.sv
// Package: constants, register map and carrier types for the converter controller
package adc_ctl_pkg;

   // ----------------------------------------------------------------
   // Clocking and timing
   // ----------------------------------------------------------------
   localparam int REF_CLK_MHZ = 100;                    // Core clock rate
   localparam int SCLK_KHZ = 1680;                      // Serial clock target, idle low
   localparam int SCLK_HALF_CYC = (REF_CLK_MHZ * 1000) / (2 * SCLK_KHZ); // Rounded down
   localparam int ICLK_WAIT_NS = 7600;                  // Internal-clock conversion wait
   localparam int ICLK_WAIT_CYC = (ICLK_WAIT_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int DELAY_MIN_US = 100;                   // Sample delay lower limit
   localparam int DELAY_MAX_US = 1000;                  // Sample delay upper limit
   localparam int CYC_PER_US = REF_CLK_MHZ;             // Cycles per microsecond
   localparam int LOG_MIN_PERIOD_US = 100000;           // Logging capped at 10 records/s
   localparam int COM_AVG_SHIFT = 2;                    // Averaging over four readings
   localparam int COM_AVG_COUNT = 4;

   // ----------------------------------------------------------------
   // Command word fields
   // ----------------------------------------------------------------
   localparam logic [15:0] START_BIT_24 = 16'h0080;     // Start bit of the 24-bit scheme
   localparam logic [15:0] START_BIT_16 = 16'h0100;     // Start bit of the 16-bit scheme
   localparam logic [15:0] READ_WORD = 16'h0000;        // Zero fill during readback
   localparam int WORD_BITS = 16;
   localparam int RESULT_BITS = 12;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CHAN_OFS = 12'h004;
   localparam logic [11:0] DELAY_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00C;
   localparam logic [11:0] RESULT_OFS = 12'h020;        // Eight words, one per channel
   localparam logic [11:0] COMV_OFS = 12'h014;

   // ----------------------------------------------------------------
   // Control register bit positions
   // ----------------------------------------------------------------
   localparam int CTRL_GO = 0;            // Write 1: start a run
   localparam int CTRL_MODE16 = 1;        // 0: 24-bit framing, 1: 16-bit framing
   localparam int CTRL_INTCLK = 2;        // Internal-clock conversion mode
   localparam int CTRL_PCYCLE = 3;        // Power cycling between readings, 24-bit framing only
   localparam int CTRL_QUICKPD = 4;       // Quick power down instead of full
   localparam int CTRL_EXTERNAL_COMMON_PAD = 5;        // Common input to external pad
   localparam int CTRL_COMMEAS = 6;       // Write 1: measure external common
   localparam int CTRL_LOG = 7;           // Logging pace
   localparam int CTRL_CONT = 8;          // Free-running sampling
   localparam int CTRL_RUN_BITS = 9;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CHAN_RST = 32'h0000_0001;
   localparam logic [31:0] DELAY_RST = 32'h0000_0064;

   // Configuration byte encodings (power mode field)
   localparam logic [1:0] PD_FULL = 2'b00;
   localparam logic [1:0] PD_QUICK = 2'b01;
   localparam logic [1:0] PD_ON_INT = 2'b10;
   localparam logic [1:0] PD_ON_EXT = 2'b11;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } adc_pins_t;

   typedef struct packed {
      logic [15:0] word;    // Word to shift out
      logic last;           // Release chip select after this word
   } xfer_req_t;

endpackage

// ### src/adc_serial_conversion_control.sv
// Host controller that drives the serial converter from APB registers
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Overview of operation
// - Power down between readings, full power converting; here only with power cycling on and 24-bit framing
// - Serial clock near 1.68MHz, idles low
// - Data stable and sampled on rising edge
// - 24-bit: zeros, start bit, channel, config
// - 24-bit: then sixteen zero bits, read result
// - Chip select held low across both segments
// - Internal clock: wait 7.6us before readback
// - Result left justified after one zero
// - 24-bit scheme sustains about 59ksps; the 100us minimum gap limits it here to about 8.4ksps
// - 16-bit scheme: chip select low continuously, here only when free-running
// - Common to ground unless external selected
// - Common measure: pad to ch0, average, restore
// - Single channel sampled 100sps to 91ksps; here about 980sps to 8.4ksps, set by the sample delay
// - Sample delay settable 100us to 1000us
// - Logging delays between channels, one record
// - Logging pace at most 10sps; here the 100ms wait after each record caps records, not samples
// ----------------------------------------------------------------
module adc_serial_conversion_control
   import adc_ctl_pkg::*;
(
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter serial pins
   output logic adc_sclk,
   output logic adc_cs_n,
   output logic adc_din,
   input wire logic adc_dout,
   // Analog switch controls
   output logic com_to_ext,
   output logic ext_to_ch0
);

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      S_IDLE = 7'b000_0001,
      S_LOAD = 7'b000_0010,
      S_SHIFT = 7'b000_0100,
      S_WAIT = 7'b000_1000,
      S_DONE = 7'b001_0000,
      S_GAP = 7'b010_0000,
      S_PDWN = 7'b100_0000
   } seq_t;

   seq_t state_ff;
   seq_t nxt_state;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_ff;          // Control bits, sticky except go and measure
   logic [7:0] chan_en_ff;        // Enabled channels
   logic [10:0] delay_us_ff;      // Gap between samples, microseconds
   logic [11:0] result_ff[8];     // Last result per channel
   logic [15:0] comv_ff;          // Averaged common voltage code
   logic busy_ff;
   logic record_ff;               // Toggles after each full record
   logic comm_ff;                 // Common-voltage measurement active
   logic [1:0] comm_cnt_ff;
   logic [13:0] comm_acc_ff;
   logic saved_ext_ff;            // Switch setting to restore
   logic [2:0] chan_ff;           // Channel being converted
   logic [1:0] seg_ff;            // 0: command word, 1: read word
   logic [15:0] tx_ff;
   logic [15:0] rx_ff;
   logic [4:0] bit_ff;
   logic [7:0] half_ff;           // Serial clock half-period counter
   logic [23:0] wait_ff;          // Gap, wait and pacing counter
   logic sclk_ff;
   logic cs_n_ff;
   logic din_ff;
   logic dout_s1_ff;              // Synchroniser first stage
   logic dout_s2_ff;

   // ----------------------------------------------------------------
   // APB decode: zero wait states, unmapped addresses error
   // ----------------------------------------------------------------
   logic acc;
   logic wr;
   logic mapped;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign mapped = (paddr == CTRL_OFS) || (paddr == CHAN_OFS) || (paddr == DELAY_OFS)
      || (paddr == STATUS_OFS) || (paddr[11:5] == RESULT_OFS[11:5]) || (paddr == COMV_OFS);

   // Ready and error answer in the access cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   // Read data registered in the setup cycle so it is ready at access
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         if (paddr == CTRL_OFS) begin
            prdata <= ctrl_ff;
         end else if (paddr == CHAN_OFS) begin
            prdata <= {24'h00_0000, chan_en_ff};
         end else if (paddr == DELAY_OFS) begin
            prdata <= {21'h00_0000, delay_us_ff};
         end else if (paddr == STATUS_OFS) begin
            prdata <= {27'h000_0000, record_ff, comm_ff, chan_ff[0], ~cs_n_ff, busy_ff};
         end else if (paddr == COMV_OFS) begin
            prdata <= {16'h0000, comv_ff};
         end else if (paddr[11:5] == RESULT_OFS[11:5]) begin
            prdata <= {20'h0_0000, result_ff[paddr[4:2]]};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Control and configuration writes; the delay is clamped to its range
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_ff <= CTRL_RST;
         chan_en_ff <= CHAN_RST[7:0];
         delay_us_ff <= DELAY_RST[10:0];
      end else if (wr) begin
         if (paddr == CTRL_OFS) begin
            ctrl_ff <= {23'h00_0000, pwdata[CTRL_RUN_BITS-1:0]};
         end else if (paddr == CHAN_OFS) begin
            chan_en_ff <= pwdata[7:0];
         end else if (paddr == DELAY_OFS) begin
            if (pwdata < DELAY_MIN_US) begin
               delay_us_ff <= 11'(DELAY_MIN_US);
            end else if (pwdata > DELAY_MAX_US) begin
               delay_us_ff <= 11'(DELAY_MAX_US);
            end else begin
               delay_us_ff <= pwdata[10:0];
            end
         end
      end else begin
         // Go and measure are self-clearing once taken
         if (state_ff == S_IDLE) begin
            ctrl_ff[CTRL_GO] <= 1'b0;
            ctrl_ff[CTRL_COMMEAS] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial data input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dout_s1_ff <= 1'b0;
         dout_s2_ff <= 1'b0;
      end else begin
         dout_s1_ff <= adc_dout;
         dout_s2_ff <= dout_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // Command word builder
   // ----------------------------------------------------------------
   logic [1:0] pd_sel;
   logic [7:0] cfg_byte;
   logic [2:0] conv_chan;
   assign conv_chan = comm_ff ? 3'd0 : chan_ff;
   // Power field: full power during conversion, internal or external clock
   assign pd_sel = ctrl_ff[CTRL_INTCLK] ? PD_ON_INT : PD_ON_EXT;
   // Start, channel, unipolar single-ended, power
   assign cfg_byte = {1'b1, conv_chan, 1'b1, 1'b1, pd_sel};
   logic [15:0] cmd_word;
   logic [15:0] pd_word;
   assign cmd_word = ctrl_ff[CTRL_MODE16] ? ({7'h00, cfg_byte, 1'b0} | START_BIT_16)
      : ({8'h00, cfg_byte} | START_BIT_24);
   // Power-down word after a reading when cycling is on
   assign pd_word = {8'h00, 1'b1, conv_chan, 2'b11,
      ctrl_ff[CTRL_QUICKPD] ? PD_QUICK : PD_FULL};

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   logic start_run;
   logic next_chan_ok;
   logic [2:0] next_chan;
   // A common measurement keeps restarting until all its readings are taken
   assign start_run = ctrl_ff[CTRL_GO] | ctrl_ff[CTRL_COMMEAS] | ctrl_ff[CTRL_CONT] | comm_ff;

   // Next enabled channel above the current one, wrap flagged
   always_comb begin
      next_chan = chan_ff;
      next_chan_ok = 1'b0;
      for (int i = 7; i >= 1; i--) begin
         if (chan_en_ff[3'(chan_ff + 3'(i))] && (32'(chan_ff) + i <= 7)) begin
            next_chan = 3'(chan_ff + 3'(i));
            next_chan_ok = 1'b1;
         end
      end
   end

   logic half_tick;
   assign half_tick = (half_ff == 8'(SCLK_HALF_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE: if (start_run) nxt_state = S_LOAD;
         S_LOAD: nxt_state = S_SHIFT;
         S_SHIFT: begin
            if (half_tick && sclk_ff && bit_ff == 5'd0) begin
               if (seg_ff == 2'd0 && !ctrl_ff[CTRL_MODE16]) begin
                  nxt_state = ctrl_ff[CTRL_INTCLK] ? S_WAIT : S_LOAD;
               end else if (seg_ff == 2'd2) begin
                  nxt_state = S_GAP;
               end else begin
                  nxt_state = S_DONE;
               end
            end
         end
         S_WAIT: if (wait_ff == 24'd0) nxt_state = S_LOAD;
         S_DONE: nxt_state = (ctrl_ff[CTRL_PCYCLE] && !ctrl_ff[CTRL_MODE16]) ? S_PDWN : S_GAP;
         S_PDWN: nxt_state = S_LOAD;
         S_GAP: if (wait_ff == 24'd0) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Word, segment, bit and clock generation
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sclk_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         din_ff <= 1'b0;
         tx_ff <= 16'h0000;
         rx_ff <= 16'h0000;
         bit_ff <= 5'd0;
         half_ff <= 8'd0;
         seg_ff <= 2'd0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               sclk_ff <= 1'b0;
               half_ff <= 8'd0;
               seg_ff <= 2'd0;
               // 16-bit free-running keeps chip select low
               if (!(ctrl_ff[CTRL_MODE16] && ctrl_ff[CTRL_CONT])) cs_n_ff <= 1'b1;
            end
            S_LOAD: begin
               cs_n_ff <= 1'b0;
               tx_ff <= (seg_ff == 2'd1) ? READ_WORD : ((seg_ff == 2'd2) ? pd_word
                  : cmd_word);
               din_ff <= 1'b0;
               bit_ff <= 5'(WORD_BITS - 1);
               half_ff <= 8'd0;
            end
            S_SHIFT: begin
               half_ff <= half_tick ? 8'd0 : half_ff + 8'd1;
               if (half_tick) begin
                  sclk_ff <= ~sclk_ff;
                  if (!sclk_ff) begin
                     // Rising edge: data set up earlier, sample input now
                     rx_ff <= {rx_ff[14:0], dout_s2_ff};
                  end else begin
                     // Falling edge: present next bit ahead of the rising edge
                     if (bit_ff != 5'd0) bit_ff <= bit_ff - 5'd1;
                  end
               end
               if (!sclk_ff) din_ff <= tx_ff[bit_ff[3:0]];
               if (half_tick && sclk_ff && bit_ff == 5'd0) begin
                  seg_ff <= (seg_ff == 2'd0 && !ctrl_ff[CTRL_MODE16]) ? 2'd1 : seg_ff;
               end
            end
            S_DONE: seg_ff <= 2'd2;
            S_GAP: begin
               sclk_ff <= 1'b0;
               if (!(ctrl_ff[CTRL_MODE16] && ctrl_ff[CTRL_CONT])) cs_n_ff <= 1'b1;
            end
            default: sclk_ff <= 1'b0;
         endcase
      end
   end

   // Wait counter: conversion wait and gap between samples
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wait_ff <= 24'd0;
      end else if (nxt_state == S_WAIT && state_ff != S_WAIT) begin
         wait_ff <= 24'(ICLK_WAIT_CYC - 1);
      end else if (nxt_state == S_GAP && state_ff != S_GAP) begin
         if (ctrl_ff[CTRL_LOG] && !next_chan_ok) begin
            wait_ff <= 24'(LOG_MIN_PERIOD_US * CYC_PER_US - 1);
         end else begin
            wait_ff <= 24'(delay_us_ff) * 24'(CYC_PER_US) - 24'd1;
         end
      end else if (wait_ff != 24'd0) begin
         wait_ff <= wait_ff - 24'd1;
      end
   end

   // Result capture, channel stepping and record tracking
   logic [11:0] res;
   assign res = rx_ff[14:3];
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         chan_ff <= 3'd0;
         busy_ff <= 1'b0;
         record_ff <= 1'b0;
         for (int i = 0; i < 8; i++) result_ff[i] <= 12'h000;
      end else begin
         busy_ff <= (state_ff != S_IDLE);
         if (state_ff == S_DONE && !comm_ff) begin
            result_ff[chan_ff] <= res;
         end
         if (state_ff == S_GAP && wait_ff == 24'd0 && !comm_ff) begin
            if (next_chan_ok && !ctrl_ff[CTRL_CONT]) begin
               chan_ff <= next_chan;
            end else if (!ctrl_ff[CTRL_CONT]) begin
               record_ff <= ~record_ff;
               chan_ff <= 3'd0;
            end
         end
      end
   end

   // Common-voltage measurement: swap switches, average, restore
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         comm_ff <= 1'b0;
         comm_cnt_ff <= 2'd0;
         comm_acc_ff <= 14'd0;
         comv_ff <= 16'h0000;
         saved_ext_ff <= 1'b0;
         com_to_ext <= 1'b0;
         ext_to_ch0 <= 1'b0;
      end else begin
         if (state_ff == S_IDLE && ctrl_ff[CTRL_COMMEAS] && !comm_ff) begin
            comm_ff <= 1'b1;
            saved_ext_ff <= ctrl_ff[CTRL_EXTERNAL_COMMON_PAD];
            com_to_ext <= 1'b0;
            ext_to_ch0 <= 1'b1;
            comm_cnt_ff <= 2'd0;
            comm_acc_ff <= 14'd0;
         end else if (comm_ff && state_ff == S_DONE) begin
            comm_acc_ff <= comm_acc_ff + {2'b00, res};
            comm_cnt_ff <= comm_cnt_ff + 2'd1;
            if (comm_cnt_ff == 2'(COM_AVG_COUNT - 1)) begin
               comv_ff <= 16'((comm_acc_ff + {2'b00, res}) >> COM_AVG_SHIFT);
               comm_ff <= 1'b0;
               com_to_ext <= saved_ext_ff;
               ext_to_ch0 <= 1'b0;
            end
         end else if (!comm_ff) begin
            com_to_ext <= ctrl_ff[CTRL_EXTERNAL_COMMON_PAD];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs straight from flip-flops
   // ----------------------------------------------------------------
   assign adc_sclk = sclk_ff;
   assign adc_cs_n = cs_n_ff;
   assign adc_din = din_ff;

endmodule

// ### test/adc_ctl_properties.sv
// Port checker of the converter controller
`timescale 1ns/10ps
module adc_ctl_properties (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Converter link and switches
   input wire logic adc_sclk,
   input wire logic adc_cs_n,
   input wire logic adc_din,
   input wire logic com_to_ext,
   input wire logic ext_to_ch0
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Clock rises within one frame; frames must hold whole words
   logic [5:0] rise_cnt_ff;
   always_ff @(posedge ref_clk) begin
      if (reset || adc_cs_n) begin
         rise_cnt_ff <= 6'h00;
      end else if ($rose(adc_sclk)) begin
         rise_cnt_ff <= rise_cnt_ff + 6'h01;
      end
   end
   a_reset_idle: assert property (disable iff (1'b0) reset |=> adc_cs_n && !adc_sclk)
      else $error("link not idle after reset");
   a_sclk_idle: assert property (adc_cs_n |-> !adc_sclk)
      else $error("serial clock high while deselected");
   a_sclk_half: assert property ($rose(adc_sclk) |-> adc_sclk[*8] ##[22:23] $fell(adc_sclk))
      else $error("serial clock high phase has wrong length");
   a_din_stable: assert property ($rose(adc_sclk) |-> $stable(adc_din))
      else $error("data changed at clock rise");
   a_cs_words: assert property ($rose(adc_cs_n) |-> rise_cnt_ff[3:0] == 4'h0)
      else $error("chip select released inside a word");
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   a_err_unmapped: assert property (psel && penable && paddr >= 12'h100 |-> pslverr)
      else $error("unmapped access not refused");
   a_err_qual: assert property (pslverr |-> pready && psel)
      else $error("error without ready");
   a_switch_excl: assert property (ext_to_ch0 |-> !com_to_ext)
      else $error("common not grounded while pad on channel 0");
endmodule

bind adc_serial_conversion_control adc_ctl_properties adc_ctl_properties_i (
   .ref_clk, .reset, .psel, .penable, .paddr, .pready, .pslverr,
   .adc_sclk, .adc_cs_n, .adc_din, .com_to_ext, .ext_to_ch0
);

// ### test/conv_model.sv
// Behavioural model of the serial converter at the far end of the link
`timescale 1ns/10ps
module conv_model #(
   parameter logic [11:0] CODE = 12'hA5C  // Result returned for every conversion
) (
   // Serial link from the controller
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout
);
   logic [7:0] hdr = 8'h00;        // Control byte being assembled
   logic [7:0] conv_byte = 8'h00;  // Last byte that started a conversion
   logic [3:0] nbits = 4'h0;       // Control bits taken, 0 when hunting a start bit
   logic [3:0] obits = 4'h0;       // Readback bits still to drive
   logic [12:0] sh = 13'h0000;     // Leading zero then result
   logic [1:0] pd_mode = 2'b11;    // Power field of the last control byte
   int zero_err = 0;               // Ones on din during readback
   realtime t_cfg = 0;             // End of the control byte
   realtime gap = 0;               // Control byte to first readback rise
   initial dout = 1'b0;
   // Take data on rising edges only
   always @(posedge sclk) begin
      if (!cs_n && obits != 4'h0) begin
         if (obits == 4'hC) gap = $realtime - t_cfg;
         if (din) zero_err++;
      end else if (!cs_n && nbits != 4'h0) begin
         hdr = {hdr[6:0], din};
         nbits++;
         if (nbits == 4'h8) begin
            // Converts only when powered; 00 full down, 01 keeps the reference
            nbits = 4'h0;
            pd_mode = hdr[1:0];
            t_cfg = $realtime;
            if (hdr[1]) begin
               conv_byte = hdr;
               sh = {1'b0, CODE};
               obits = 4'hD;
            end
         end
      end else if (!cs_n && din) begin
         // Leading zeros skipped until the start bit
         nbits = 4'h1;
         hdr = 8'h01;
      end
   end
   // Drive on falling edges so data is settled at the rise
   always @(negedge sclk) begin
      if (!cs_n && obits != 4'h0) begin
         dout = sh[12];
         sh = {sh[11:0], 1'b0};
         obits--;
      end
   end
   // Released line: show the inverse, drop any half frame
   always @(posedge cs_n) begin
      dout = ~dout;
      nbits = 4'h0;
      obits = 4'h0;
   end
endmodule

// ### test/adc_serial_conversion_control_test.sv
// Self-checking bench of the converter controller
`timescale 1ns/10ps
module adc_serial_conversion_control_test import adc_ctl_pkg::*; ;
   localparam logic [11:0] CODE = 12'hA5C; // Model result
   // Clock, reset and APB
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Link and switches
   logic adc_sclk;
   logic adc_cs_n;
   logic adc_din;
   logic adc_dout;
   logic com_to_ext;
   logic ext_to_ch0;
   // Last read word, error flag and tallies
   logic [31:0] q;
   logic e;
   int fails = 0;
   int compares = 0;
   always #5 ref_clk = ~ref_clk;
   adc_serial_conversion_control adc_serial_conversion_control_i (
      .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .adc_sclk, .adc_cs_n, .adc_din, .adc_dout, .com_to_ext, .ext_to_ch0
   );
   conv_model #(.CODE(CODE)) conv_model_i (
      .sclk(adc_sclk), .cs_n(adc_cs_n), .din(adc_din), .dout(adc_dout)
   );
   task automatic test_done();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge follows so calls never collide
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(pready), 32'h0000_0001);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask
   // Poll one status bit until it clears, bounded
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFS, 32'h0000_0000);
         n++;
      end while (q[b] !== 1'b0 && n < 20000);
      while (adc_cs_n !== 1'b1 && n < 24000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic t_reset();
      chk(32'({adc_cs_n, adc_sclk}), 32'h0000_0002);
      rd(CTRL_OFS, CTRL_RST);
      rd(CHAN_OFS, CHAN_RST);
      rd(DELAY_OFS, DELAY_RST);
      rd(12'h100, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      $display("reset test done");
   endtask
   task automatic t_delay();
      apb(1'b1, DELAY_OFS, 32'h0000_0005);
      rd(DELAY_OFS, 32'h0000_0064);
      apb(1'b1, DELAY_OFS, 32'h0000_07D0);
      rd(DELAY_OFS, 32'h0000_03E8);
      apb(1'b1, DELAY_OFS, 32'h0000_0064);
      rd(DELAY_OFS, 32'h0000_0064);
      $display("delay test done");
   endtask
   task automatic conv(input logic [31:0] ctrl, input logic [1:0] pd);
      apb(1'b1, CTRL_OFS, ctrl);
      poll(0);
      rd(RESULT_OFS, {20'h0_0000, CODE});
      chk(32'(conv_model_i.conv_byte[7:2]), 32'h0000_0023);
      chk(32'(conv_model_i.pd_mode), 32'(pd));
      chk(32'(conv_model_i.zero_err), 32'h0000_0000);
      $display("conversion test done, control %h", ctrl);
   endtask
   task automatic t_com();
      int n;
      apb(1'b1, CTRL_OFS, 32'h0000_0020);
      @(posedge ref_clk);
      chk(32'(com_to_ext), 32'h0000_0001);
      apb(1'b1, CTRL_OFS, 32'h0000_0060);
      n = 0;
      // The gap of the previous run must end before the measurement starts
      while (ext_to_ch0 !== 1'b1 && n < 12000) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'({ext_to_ch0, com_to_ext}), 32'h0000_0002);
      poll(3);
      chk(32'({ext_to_ch0, com_to_ext}), 32'h0000_0001);
      chk(32'(conv_model_i.conv_byte[7:2]), 32'h0000_0023);
      rd(COMV_OFS, {20'h0_0000, CODE});
      $display("common test done");
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_delay();
      conv(32'h0000_0001, PD_ON_EXT);
      conv(32'h0000_0005, PD_ON_INT);
      chk(32'(conv_model_i.gap >= 7600.0), 32'h0000_0001);
      conv(32'h0000_0009, PD_FULL);
      conv(32'h0000_0019, PD_QUICK);
      t_com();
      test_done();
   end
   // Hang guard
   initial begin
      #1500000;
      fails++;
      test_done();
   end
endmodule
